// >>> design/bv4_cfg.svh
// constants for the fourth buck converter voltage-select register bank
// assumes inclusion by bare name from the package and design modules
`ifndef BV4_CFG_SVH
`define BV4_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BV4_OFS_OP        8'h0d
`define BV4_OFS_AVS       8'h0e
`define BV4_OFS_LIMIT     8'h0f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BV4_CODE_MSB      5
`define BV4_OP_SRCSEL     6
`define BV4_OP_UNUSED     7
`define BV4_AVS_SAVE      6
`define BV4_AVS_EN        7
`define BV4_LIM_RNG_LSB   6

// ----------------------------------------------------------------
// reset values and special codes
// ----------------------------------------------------------------
`define BV4_RST_OP        8'h00
`define BV4_RST_AVS       8'h00
`define BV4_RST_LIMIT     8'hff
`define BV4_CEIL_OPEN_HI  6'h3f
`define BV4_CEIL_OPEN_LO  6'h00

// ----------------------------------------------------------------
// voltage ranges, microvolts
// ----------------------------------------------------------------
`define BV4_BASE_LO_UV    22'd500000
`define BV4_BASE_HI_UV    22'd700000
`define BV4_STEP_FINE_UV  22'd12500
`define BV4_STEP_MID_UV   22'd25000
`define BV4_STEP_WIDE_UV  22'd50000

`endif

// >>> design/bv4_pkg.sv
// types shared by the voltage-select register bank and its mapper
// assumes bv4_cfg.svh on the include path
`include "bv4_cfg.svh"

package bv4_pkg;

  // ----------------------------------------------------------------
  // range field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BV4_RNG_FINE_LO = 2'h0,
    BV4_RNG_FINE_HI = 2'h1,
    BV4_RNG_MID     = 2'h2,
    BV4_RNG_WIDE    = 2'h3
  } bv4_range_t;

  // ----------------------------------------------------------------
  // converter control bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       light_load_saving;
    bv4_range_t range;
    logic [5:0] code;
  } bv4_ctrl_t;

endpackage

// >>> design/bv4_volt_map.sv
// maps a voltage code and range field to a target in microvolts
// assumes a stable code and range; output is registered
`include "bv4_cfg.svh"

module bv4_volt_map (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // selected setting
  input  wire bv4_pkg::bv4_ctrl_t ctrl_i,
  // target voltage
  output logic [21:0]            target_uv_o
);

  // ----------------------------------------------------------------
  // base plus code times step
  // ----------------------------------------------------------------
  function automatic logic [21:0] to_uv(input bv4_pkg::bv4_range_t rng,
                                        input logic [5:0] code);
    logic [21:0] base;
    logic [21:0] step;
    base = `BV4_BASE_LO_UV;
    step = `BV4_STEP_FINE_UV;
    unique case (rng)
      bv4_pkg::BV4_RNG_FINE_LO: begin
        base = `BV4_BASE_LO_UV;
        step = `BV4_STEP_FINE_UV;
      end
      bv4_pkg::BV4_RNG_FINE_HI: begin
        base = `BV4_BASE_HI_UV;
        step = `BV4_STEP_FINE_UV;
      end
      bv4_pkg::BV4_RNG_MID: begin
        base = `BV4_BASE_LO_UV;
        step = `BV4_STEP_MID_UV;
      end
      bv4_pkg::BV4_RNG_WIDE: begin
        base = `BV4_BASE_LO_UV;
        step = `BV4_STEP_WIDE_UV;
      end
    endcase
    // widest product 63 * 50000 fits 22 bits
    return 22'(base + 22'(step * {16'h0000, code}));
  endfunction

  wire logic [21:0] uv_d = to_uv(ctrl_i.range, ctrl_i.code); // [R8]

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_uv_o <= 22'h000000;
    end else begin
      target_uv_o <= uv_d;
    end
  end

endmodule

// >>> design/bv4_regs.sv
// register bank and voltage source selection for the fourth buck
// assumes a synchronous register port from the serial control interface
//
// Operation
// R1 - select bit 0 uses operating setting
// R2 - select bit 1 uses scaled setting
// R3 - strap low lets pin choose setting
// R4 - enable bit switches converter off/on
// R5 - saving mode only when mode bit 0
// R6 - code interpreted by the range field
// R7 - power-on reset restores default contents
// R8 - range codes map to four voltage spans
// R9 - codes above ceiling replaced by ceiling
// R10 - ceiling not 3f/00 locks limit register
// R11 - bit 7 of operating reads zero
`include "bv4_cfg.svh"

module bv4_regs #(
  parameter logic [7:0] OP_RST    = `BV4_RST_OP,
  parameter logic [7:0] AVS_RST   = `BV4_RST_AVS,
  parameter logic [7:0] LIMIT_RST = `BV4_RST_LIMIT
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // register port
  input  wire logic               wr_en_i,
  input  wire logic               rd_en_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  output logic [7:0]              rdata_o,
  // pins
  input  wire logic               pin_strap_two_i,
  input  wire logic               voltage_source_pin_i,
  input  wire logic               converter_mode_bit_i,
  // converter control
  output bv4_pkg::bv4_ctrl_t      ctrl_o,
  output logic                    use_scaled_o,
  output logic                    limit_locked_o,
  output logic [21:0]             target_uv_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // async assert, release on one edge so every flop leaves reset together
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] op_q;
  logic [7:0] avs_q;
  logic [7:0] limit_q;
  logic [7:0] rdata_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // one compare per register, shared by the write and read paths
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  wire logic       hit_op    = reg_hit(addr_i, `BV4_OFS_OP);
  wire logic       hit_avs   = reg_hit(addr_i, `BV4_OFS_AVS);
  wire logic       hit_limit = reg_hit(addr_i, `BV4_OFS_LIMIT);

  // ----------------------------------------------------------------
  // stored fields
  // ----------------------------------------------------------------
  wire logic       op_srcsel = op_q[`BV4_OP_SRCSEL];
  wire logic [5:0] op_code   = op_q[`BV4_CODE_MSB:0];
  wire logic       avs_en    = avs_q[`BV4_AVS_EN];
  wire logic       avs_save  = avs_q[`BV4_AVS_SAVE];
  wire logic [5:0] avs_code  = avs_q[`BV4_CODE_MSB:0];
  wire logic [5:0] ceiling   = limit_q[`BV4_CODE_MSB:0];
  wire logic [1:0] range_f   = limit_q[7:`BV4_LIM_RNG_LSB];

  // a ceiling written to anything but 3f or 00 is permanent until power-on reset
  wire logic locked = (ceiling != `BV4_CEIL_OPEN_HI) &&
                      (ceiling != `BV4_CEIL_OPEN_LO);       // [R10]

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  // clamp applies at write time, so readback shows the clamped code
  function automatic logic [5:0] clamp(input logic [5:0] code,
                                       input logic [5:0] ceil);
    return (code > ceil) ? ceil : code;
  endfunction

  wire logic [5:0] wr_code = clamp(wdata_i[`BV4_CODE_MSB:0], ceiling); // [R9]

  wire logic [7:0] op_wr  = {1'b0, wdata_i[`BV4_OP_SRCSEL], wr_code}; // [R11]
  wire logic [7:0] avs_wr = {wdata_i[`BV4_AVS_EN], wdata_i[`BV4_AVS_SAVE],
                             wr_code};                              // [R9]

  // unmapped addresses fall through and leave every register untouched
  wire logic op_we    = wr_en_i && hit_op;
  wire logic avs_we   = wr_en_i && hit_avs;
  wire logic limit_we = wr_en_i && hit_limit && !locked;            // [R10]

  wire logic [7:0] op_d    = op_we ? op_wr : op_q;
  wire logic [7:0] avs_d   = avs_we ? avs_wr : avs_q;
  wire logic [7:0] limit_d = limit_we ? wdata_i : limit_q;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped addresses read as zero
  wire logic [7:0] rd_sel = hit_op    ? {1'b0, op_q[6:0]} :         // [R11]
                            hit_avs   ? avs_q :
                            hit_limit ? limit_q : 8'h00;
  wire logic [7:0] rdata_d = rd_en_i ? rd_sel : rdata_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // clamp and lock act before this point, so these stay plain loads
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      op_q <= OP_RST & 8'h7f;                                       // [R7]
    end else begin
      op_q <= op_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      avs_q <= AVS_RST;                                             // [R7]
    end else begin
      avs_q <= avs_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      limit_q <= LIMIT_RST;
    end else begin
      limit_q <= limit_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // source selection and converter control
  // ----------------------------------------------------------------
  // pin only takes effect while the select bit is held at 0
  wire logic pin_choice = !pin_strap_two_i && voltage_source_pin_i; // [R3]
  wire logic scaled     = op_srcsel || pin_choice; // [R1] [R2]

  wire logic [5:0] sel_code = scaled ? avs_code                     // [R2]
                                     : op_code;                     // [R1]

  bv4_pkg::bv4_ctrl_t ctrl_d;
  assign ctrl_d.enable            = avs_en;                         // [R4]
  // mode bit is a live pin, so saving drops out without a write
  assign ctrl_d.light_load_saving = avs_save &&
                                    !converter_mode_bit_i;          // [R5]
  assign ctrl_d.range             = bv4_pkg::bv4_range_t'(range_f); // [R6]
  assign ctrl_d.code              = sel_code;

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // registered so the converter never sees a half-updated setting
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ctrl_o <= '0;
    end else begin
      ctrl_o <= ctrl_d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      use_scaled_o <= 1'b0;
    end else begin
      use_scaled_o <= scaled;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      limit_locked_o <= 1'b0;
    end else begin
      limit_locked_o <= locked;
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // voltage mapping
  // ----------------------------------------------------------------
  bv4_volt_map u_map (
    .clk_i       (clk_i),
    .rst_n_i     (rst_sync_q),
    .ctrl_i      (ctrl_o),
    .target_uv_o (target_uv_o)                                      // [R6] [R8]
  );

endmodule

// >>> dv/bv4_regs_assertions.sv
// checker for the voltage-select register bank
// assumes it is bound onto bv4_regs, one clock domain
`include "bv4_cfg.svh"

module bv4_regs_chk (
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  // register port
  input wire logic               wr_en_i,
  input wire logic               rd_en_i,
  input wire logic [7:0]         addr_i,
  input wire logic [7:0]         wdata_i,
  input wire logic [7:0]         rdata_o,
  // pins
  input wire logic               pin_strap_two_i,
  input wire logic               voltage_source_pin_i,
  input wire logic               converter_mode_bit_i,
  // converter control
  input wire bv4_pkg::bv4_ctrl_t ctrl_o,
  input wire logic               use_scaled_o,
  input wire logic               limit_locked_o,
  input wire logic [21:0]        target_uv_o
);
  logic [2:0]  age_q;
  logic [21:0] step_uv;
  logic [21:0] exp_uv;
  // skip the edges where the reset synchroniser still settles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  assign step_uv = !ctrl_o.range[1] ? `BV4_STEP_FINE_UV :
                   ctrl_o.range[0] ? `BV4_STEP_WIDE_UV : `BV4_STEP_MID_UV;
  assign exp_uv = (ctrl_o.range == 2'h1 ? `BV4_BASE_HI_UV : `BV4_BASE_LO_UV)
                  + 22'(ctrl_o.code) * step_uv;
  default clocking @(posedge clk_i); endclocking
  default disable iff (age_q != 3'h7);
  property p_rst_clear;
    disable iff (1'b0) !rst_n_i |-> ctrl_o == '0 && rdata_o == 8'h00;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not cleared in reset");
  property p_pin_pick;
    (!pin_strap_two_i && voltage_source_pin_i)[*2] |=> use_scaled_o;
  endproperty
  a_pin_pick: assert property (p_pin_pick)
    else $error("pin did not pick scaled setting");
  property p_saving;
    ctrl_o.light_load_saving |-> !$past(converter_mode_bit_i);
  endproperty
  a_saving: assert property (p_saving)
    else $error("saving mode with mode bit set");
  property p_top_zero;
    rd_en_i && addr_i == `BV4_OFS_OP |-> ##1 !rdata_o[7];
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("reserved bit read as one");
  property p_volt;
    target_uv_o == $past(exp_uv);
  endproperty
  a_volt: assert property (p_volt)
    else $error("target voltage wrong");
  property p_lock_hold;
    limit_locked_o |=> limit_locked_o;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock released without reset");
  property p_range_frozen;
    limit_locked_o && $past(limit_locked_o) |-> $stable(ctrl_o.range);
  endproperty
  a_range_frozen: assert property (p_range_frozen)
    else $error("range changed while locked");
  property p_enable_hold;
    !wr_en_i[*3] |=> $stable(ctrl_o.enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("enable changed without write");
  c_write_op: cover property (wr_en_i && addr_i == `BV4_OFS_OP);
  c_locked: cover property ($rose(limit_locked_o));
  c_scaled: cover property ($rose(use_scaled_o));
endmodule

bind bv4_regs bv4_regs_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .pin_strap_two_i(pin_strap_two_i),
  .voltage_source_pin_i(voltage_source_pin_i),
  .converter_mode_bit_i(converter_mode_bit_i), .ctrl_o(ctrl_o),
  .use_scaled_o(use_scaled_o), .limit_locked_o(limit_locked_o),
  .target_uv_o(target_uv_o));

// >>> dv/test_bv4_regs.sv
// self-checking bench for the voltage-select register bank
// assumes bv4_pkg and the bound checker are compiled first
module test_bv4_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_n_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
  logic strap = 1'b1, pin = 1'b0, mode = 1'b0, use_scaled_o, limit_locked_o;
  logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [21:0] target_uv_o;
  bv4_pkg::bv4_ctrl_t ctrl_o;
  int miscompares = 0, comparisons = 0;
  // base plus twice the step for each range code
  logic [21:0] exp_t [4] = '{22'd525000, 22'd725000, 22'd550000, 22'd600000};

  bv4_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .pin_strap_two_i(strap), .voltage_source_pin_i(pin),
    .converter_mode_bit_i(mode), .ctrl_o(ctrl_o), .use_scaled_o(use_scaled_o),
    .limit_locked_o(limit_locked_o), .target_uv_o(target_uv_o));

  always #20 clk_i = ~clk_i;

  task stop_test;
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // outputs lag a request by up to three edges
  task settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    settle;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_en_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    settle;
    chk(rdata_o, e);
  endtask
  task pins(input logic s, input logic p, input logic m);
    @(posedge clk_i);
    strap <= s; pin <= p; mode <= m;
    settle;
  endtask

  initial begin
    #200000;
    miscompares++;
    stop_test;
  end
  initial begin
    rst_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(8'h0d, 8'h00);
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'hff);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    wr(8'h0d, 8'hc5);
    rd(8'h0d, 8'h45);
    chk(use_scaled_o, 1'b1);
    chk(target_uv_o, 22'd500000);
    wr(8'h0d, 8'h02);
    chk(use_scaled_o, 1'b0);
    pins(1'b1, 1'b1, 1'b0);
    chk(use_scaled_o, 1'b0);
    pins(1'b0, 1'b1, 1'b0);
    chk(use_scaled_o, 1'b1);
    pins(1'b0, 1'b0, 1'b0);
    chk(use_scaled_o, 1'b0);
    wr(8'h0e, 8'hc9);
    chk(ctrl_o.enable, 1'b1);
    chk(ctrl_o.light_load_saving, 1'b1);
    pins(1'b0, 1'b0, 1'b1);
    chk(ctrl_o.light_load_saving, 1'b0);
    wr(8'h0e, 8'h09);
    chk(ctrl_o.enable, 1'b0);
    for (int r = 0; r < 4; r++) begin
      wr(8'h0f, {r[1:0], 6'h3f});
      chk(target_uv_o, exp_t[r]);
    end
    wr(8'h0f, 8'h4a);
    chk(limit_locked_o, 1'b1);
    wr(8'h0d, 8'h3c);
    rd(8'h0d, 8'h0a);
    wr(8'h0e, 8'h3f);
    rd(8'h0e, 8'h0a);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 8'h4a);
    chk(target_uv_o, 22'd825000);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(8'h0f, 8'hff);
    chk(limit_locked_o, 1'b0);
    wr(8'h0f, 8'h80);
    chk(limit_locked_o, 1'b0);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 8'hff);
    stop_test;
  end
endmodule
